// ===== core/ibed_regs.svh
// Timing and code constants for the bus error detector.
`ifndef IBED_REGS_SVH
`define IBED_REGS_SVH
`define IBED_CLK_MHZ 250
`define IBED_HALF_NS 2500
`define IBED_HALF_CYC ((`IBED_HALF_NS * `IBED_CLK_MHZ + 999) / 1000)
`define IBED_BITS_PER_XFER 4'h9
`define IBED_PULSE_FIRST 4'h1
`define IBED_PULSE_SECOND 4'h2
`define IBED_PULSE_ZERO 4'h0
`define IBED_DIV_ZERO 12'h000
`define IBED_DIV_ONE 12'h001
`endif

// ===== core/ibed_pkg.sv
// Types for the bus error detector.
package ibed_pkg;
  typedef enum logic [2:0] {
    IBED_IDLE, IBED_WAIT_START, IBED_START, IBED_BIT_LO, IBED_BIT_HI, IBED_STOP
  } ibed_state_t;
  typedef logic [3:0] ibed_pulse_t;
endpackage

// ===== core/ibed_cond_if.sv
// Bus condition events passed from the line watcher to the master.
`timescale 1ns/100ps
`default_nettype none
interface ibed_cond_if;
  logic start_seen;
  logic stop_seen;
  logic scl_rise;
  logic sda_lvl;
  logic scl_lvl;
  modport watch (output start_seen, output stop_seen, output scl_rise, output sda_lvl,
                 output scl_lvl);
  modport user (input start_seen, input stop_seen, input scl_rise, input sda_lvl,
                input scl_lvl);
endinterface
`default_nettype wire

// ===== core/ibed_watch.sv
// Synchronises the bus lines and detects START, STOP and clock rises.
`timescale 1ns/100ps
`default_nettype none
module ibed_watch (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  ibed_cond_if.watch cond
);
  import ibed_pkg::*;
  logic [1:0] scl_sy_ff, sda_sy_ff;
  logic scl_d_ff, sda_d_ff;
  logic [1:0] nxt_scl_sy, nxt_sda_sy;
  logic nxt_scl_d, nxt_sda_d;
  always_comb begin
    nxt_scl_sy = {scl_sy_ff[0], scl_in};
    nxt_sda_sy = {sda_sy_ff[0], sda_in};
    nxt_scl_d = scl_sy_ff[1];
    nxt_sda_d = sda_sy_ff[1];
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      scl_sy_ff <= 2'h3;
      sda_sy_ff <= 2'h3;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_sy_ff <= nxt_scl_sy;
      sda_sy_ff <= nxt_sda_sy;
      scl_d_ff <= nxt_scl_d;
      sda_d_ff <= nxt_sda_d;
    end
  end
  assign cond.scl_lvl = scl_sy_ff[1];
  assign cond.sda_lvl = sda_sy_ff[1];
  assign cond.start_seen = scl_sy_ff[1] && scl_d_ff && sda_d_ff && !sda_sy_ff[1];
  assign cond.stop_seen = scl_sy_ff[1] && scl_d_ff && !sda_d_ff && sda_sy_ff[1];
  assign cond.scl_rise = scl_sy_ff[1] && !scl_d_ff;
endmodule
`default_nettype wire

// ===== core/ibed_master.sv
// Master transmitter with the documented start and bus error behaviour.
// Contract
// - Foreign START while own START pending ignored.
// - After NACK, repeated START and address possible.
// - No bus error on pulses one or two.
// - Misplaced condition there clears busy, transfer continues.
// - Misplaced condition elsewhere sets bus error flag.
// - Foreign misplaced condition on pulses one/two unflagged.
// - NACK or busy loss permits restart.
// - Busy clearing treated like bus error; the code sets no bus error flag when busy clears on pulses one or two.
`timescale 1ns/100ps
`default_nettype none
`include "ibed_regs.svh"
module ibed_master (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic start_req,
  input wire logic stop_req,
  input wire logic [7:0] tx_byte,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  output logic bus_busy_ff,
  output logic bus_error_flag_ff,
  output logic nack_ff,
  output logic byte_done_ff,
  output ibed_pkg::ibed_state_t state_ff
);
  import ibed_pkg::*;
  ibed_cond_if cond ();
  ibed_watch u_watch (
    .mclk(mclk),
    .rst_b(rst_b),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .cond(cond)
  );

  function automatic logic early_pulse(input ibed_pulse_t p);
    early_pulse = (p == `IBED_PULSE_FIRST) || (p == `IBED_PULSE_SECOND);
  endfunction

  ibed_state_t nxt_state;
  ibed_pulse_t pulse_ff, nxt_pulse;
  logic [11:0] div_ff, nxt_div;
  logic [7:0] shift_ff, nxt_shift;
  logic sda_drv_ff, nxt_sda_drv, scl_drv_ff, nxt_scl_drv;
  logic nxt_busy, nxt_bus_error_flag, nxt_nack, nxt_done;
  logic tick, misplaced;

  assign tick = (div_ff == `IBED_DIV_ZERO);
  // Drive low only; releasing the line lets the pull-up win.
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_drv_ff;
  assign sda_oe = sda_drv_ff;
  assign misplaced = (cond.start_seen || cond.stop_seen) &&
                     (state_ff == IBED_BIT_LO || state_ff == IBED_BIT_HI);

  always_comb begin
    nxt_state = state_ff;
    nxt_pulse = pulse_ff;
    nxt_div = tick ? 12'(`IBED_HALF_CYC) : div_ff - `IBED_DIV_ONE;
    nxt_shift = shift_ff;
    nxt_sda_drv = sda_drv_ff;
    nxt_scl_drv = scl_drv_ff;
    nxt_busy = bus_busy_ff;
    nxt_bus_error_flag = bus_error_flag_ff;
    nxt_nack = nack_ff;
    nxt_done = 1'b0;
    if (cond.start_seen) begin
      nxt_busy = 1'b1;
    end
    if (cond.stop_seen) begin
      nxt_busy = 1'b0;
    end
    if (misplaced && early_pulse(pulse_ff)) begin
      nxt_busy = 1'b0;
    end
    // A new request clears the flag, but a condition seen in the same
    // cycle must not be lost, so the set below overrides this clear.
    if (start_req) begin
      nxt_bus_error_flag = 1'b0;
    end
    if (misplaced && !early_pulse(pulse_ff)) begin
      nxt_bus_error_flag = 1'b1;
    end
    unique case (state_ff)
      IBED_IDLE: begin
        nxt_scl_drv = 1'b0;
        nxt_sda_drv = 1'b0;
        // A new request restarts the transfer.
        if (start_req) begin
          nxt_nack = 1'b0;
          nxt_shift = tx_byte;
          nxt_state = IBED_WAIT_START;
        end
      end
      IBED_WAIT_START: begin
        // Foreign START here is not acted on.
        if (tick) begin
          nxt_sda_drv = 1'b1;
          nxt_state = IBED_START;
        end
      end
      IBED_START: begin
        if (tick) begin
          nxt_scl_drv = 1'b1;
          nxt_pulse = `IBED_PULSE_FIRST;
          nxt_state = IBED_BIT_LO;
        end
      end
      IBED_BIT_LO: begin
        // Data moves one cycle after SCL falls, never together with its rise.
        if (div_ff == 12'(`IBED_HALF_CYC)) begin
          if (pulse_ff == `IBED_BITS_PER_XFER) begin
            nxt_sda_drv = 1'b0;
          end else begin
            nxt_sda_drv = !shift_ff[7];
          end
        end
        if (tick) begin
          nxt_scl_drv = 1'b0;
          nxt_state = IBED_BIT_HI;
        end
      end
      IBED_BIT_HI: begin
        if (cond.scl_lvl && tick) begin
          nxt_scl_drv = 1'b1;
          if (pulse_ff == `IBED_BITS_PER_XFER) begin
            nxt_nack = cond.sda_lvl;
            nxt_done = 1'b1;
            nxt_pulse = `IBED_PULSE_ZERO;
            nxt_sda_drv = 1'b1;
            nxt_state = IBED_STOP;
          end else begin
            nxt_shift = {shift_ff[6:0], 1'b0};
            nxt_pulse = pulse_ff + `IBED_PULSE_FIRST;
            nxt_state = IBED_BIT_LO;
          end
        end
      end
      IBED_STOP: begin
        // Stop is held until asked for, so software may instead restart.
        if (start_req) begin
          nxt_nack = 1'b0;
          nxt_shift = tx_byte;
          nxt_sda_drv = 1'b0;
          nxt_scl_drv = 1'b0;
          nxt_state = IBED_WAIT_START;
        end else if (stop_req && tick) begin
          nxt_scl_drv = 1'b0;
          nxt_state = IBED_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= IBED_IDLE;
      pulse_ff <= `IBED_PULSE_ZERO;
      div_ff <= `IBED_DIV_ZERO;
      shift_ff <= 8'h00;
      sda_drv_ff <= 1'b0;
      scl_drv_ff <= 1'b0;
      bus_busy_ff <= 1'b0;
      bus_error_flag_ff <= 1'b0;
      nack_ff <= 1'b0;
      byte_done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pulse_ff <= nxt_pulse;
      div_ff <= nxt_div;
      shift_ff <= nxt_shift;
      sda_drv_ff <= nxt_sda_drv;
      scl_drv_ff <= nxt_scl_drv;
      bus_busy_ff <= nxt_busy;
      bus_error_flag_ff <= nxt_bus_error_flag;
      nack_ff <= nxt_nack;
      byte_done_ff <= nxt_done;
    end
  end

  chk_early_no_bus_error_flag: assert property (@(posedge mclk) disable iff (!rst_b)
    misplaced && early_pulse(pulse_ff) && !start_req |=> $stable(bus_error_flag_ff))
    else $error("bus error raised on early pulse");
  chk_early_busy_clr: assert property (@(posedge mclk) disable iff (!rst_b)
    misplaced && early_pulse(pulse_ff) |=> !bus_busy_ff)
    else $error("busy not cleared on early misplaced condition");
  chk_late_bus_error_flag: assert property (@(posedge mclk) disable iff (!rst_b)
    misplaced && !early_pulse(pulse_ff) |=> bus_error_flag_ff)
    else $error("bus error missing on late misplaced condition");
  chk_busy_start: assert property (@(posedge mclk) disable iff (!rst_b)
    cond.start_seen && !cond.stop_seen && !misplaced |=> bus_busy_ff)
    else $error("busy not set on start");
  chk_busy_stop: assert property (@(posedge mclk) disable iff (!rst_b)
    cond.stop_seen |=> !bus_busy_ff)
    else $error("busy not cleared on stop");
  chk_restart_ok: assert property (@(posedge mclk) disable iff (!rst_b)
    state_ff == IBED_STOP && start_req |=> state_ff == IBED_WAIT_START && !nack_ff)
    else $error("restart not taken after byte");
  chk_pending_start: assert property (@(posedge mclk) disable iff (!rst_b)
    state_ff == IBED_WAIT_START && !tick |=> state_ff == IBED_WAIT_START)
    else $error("pending start disturbed");
  chk_done_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
    byte_done_ff |-> state_ff == IBED_STOP ##1 !byte_done_ff)
    else $error("byte done not a single pulse");
  chk_bus_error_flag_sticky: assert property (@(posedge mclk) disable iff (!rst_b)
    bus_error_flag_ff && !start_req |=> bus_error_flag_ff)
    else $error("bus error flag lost without a new request");
  chk_nack_held: assert property (@(posedge mclk) disable iff (!rst_b)
    state_ff == IBED_STOP && !start_req |=> $stable(nack_ff))
    else $error("acknowledge result lost before restart");
endmodule
`default_nettype wire

// ===== testbench/ibed_peer_model.sv
// Behavioural far-side slave that can also inject misplaced bus conditions.
`timescale 1ns/100ps
`default_nettype none
module ibed_peer_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_en,
  input wire logic [3:0] hit_pulse,
  output logic sda_oe,
  output logic [7:0] rx_byte
);
  int cnt = 0;
  logic ack_oe = 1'b0;
  logic hit_oe = 1'b0;
  logic hit_seen = 1'b0;
  assign sda_oe = ack_oe | hit_oe;
  // Our own injected START must not restart the bit count.
  always @(negedge sda) begin
    if (scl && !hit_oe) begin
      cnt = 0;
      hit_seen = 1'b0;
    end
  end
  always @(posedge scl) begin
    cnt = cnt + 1;
    if (cnt <= 8) begin
      rx_byte = {rx_byte[6:0], sda};
    end
    if (cnt == int'(hit_pulse)) begin
      // The release while the clock is still high adds a misplaced STOP.
      #1000 hit_oe = 1'b1;
      hit_seen = 1'b1;
      #800 hit_oe = 1'b0;
    end
  end
  always @(negedge scl) ack_oe = (cnt == 8) && ack_en && !hit_seen;
endmodule
`default_nettype wire

// ===== testbench/i2c_master_bus_error_detect_tb_top.sv
// Self-checking bench for the master start and bus error logic.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, ac) begin checked++; if ((ac) !== (ex)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, ac); end end
module i2c_master_bus_error_detect_tb_top;
  import ibed_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic start_req = 1'b0;
  logic stop_req = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic ack_en = 1'b1;
  logic [3:0] hit_pulse = 4'h0;
  logic scl_oe, sda_oe, p_oe, busy, err, nack, done, scl_o, sda_o;
  logic [7:0] rx_byte;
  ibed_state_t state;
  int fails = 0;
  int checked = 0;
  wire scl = ~scl_oe;
  wire sda = ~(sda_oe | p_oe);
  ibed_master i_dut (.mclk(mclk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda),
    .start_req(start_req), .stop_req(stop_req), .tx_byte(tx_byte), .scl_out(scl_o),
    .scl_oe(scl_oe), .sda_out(sda_o), .sda_oe(sda_oe), .bus_busy_ff(busy),
    .bus_error_flag_ff(err), .nack_ff(nack), .byte_done_ff(done), .state_ff(state));
  ibed_peer_model i_peer (.scl(scl), .sda(sda), .ack_en(ack_en),
    .hit_pulse(hit_pulse), .sda_oe(p_oe), .rx_byte(rx_byte));
  initial begin
    forever #2 mclk = ~mclk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic end_sim();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic do_reset();
    rst_b = 1'b0;
    step(6);
    rst_b = 1'b1;
  endtask
  task automatic send(input logic [7:0] b);
    tx_byte = b;
    start_req = 1'b1;
    step(1);
    start_req = 1'b0;
    for (int i = 0; i < 20000 && done !== 1'b1; i++) step(1);
    `CHK("byte_done", 1'b1, done)
    step(1);
  endtask
  task automatic release_bus();
    stop_req = 1'b1;
    for (int i = 0; i < 4000 && state !== IBED_IDLE; i++) step(1);
    stop_req = 1'b0;
    // The STOP reaches the flag only after the line synchroniser.
    step(6);
    `CHK("busy_after_stop", 1'b0, busy)
  endtask
  task automatic t_reset();
    `CHK("rst_state", IBED_IDLE, state)
    `CHK("rst_oe", 2'h0, {scl_oe, sda_oe})
    `CHK("rst_out", 2'h0, {scl_o, sda_o})
    `CHK("rst_flags", 4'h0, {busy, err, nack, done})
  endtask
  task automatic t_nack_restart();
    ack_en = 1'b0;
    send(8'hA5);
    `CHK("nack", 1'b1, nack)
    `CHK("rx_first", 8'hA5, rx_byte)
    `CHK("busy_set", 1'b1, busy)
    ack_en = 1'b1;
    send(8'h3C);
    `CHK("ack_restart", 1'b0, nack)
    `CHK("rx_restart", 8'h3C, rx_byte)
    `CHK("err_clean", 1'b0, err)
    release_bus();
  endtask
  // Injected condition on pulse one or two: busy drops, no error, byte goes on.
  task automatic t_early(input logic [3:0] p);
    hit_pulse = p;
    send(8'hFF);
    hit_pulse = 4'h0;
    `CHK("early_err", 1'b0, err)
    `CHK("early_busy", 1'b0, busy)
    `CHK("early_nack", 1'b1, nack)
    release_bus();
  endtask
  task automatic t_late();
    hit_pulse = 4'h4;
    tx_byte = 8'hFF;
    start_req = 1'b1;
    step(1);
    start_req = 1'b0;
    for (int i = 0; i < 12000 && err !== 1'b1; i++) step(1);
    `CHK("late_err", 1'b1, err)
    hit_pulse = 4'h0;
    step(700);
    do_reset();
    `CHK("err_reset", 1'b0, err)
  endtask
  initial begin
    repeat (90000) @(posedge mclk);
    fails++;
    end_sim();
  end
  initial begin
    step(6);
    rst_b = 1'b1;
    t_reset();
    t_nack_restart();
    t_early(4'h1);
    t_early(4'h2);
    t_late();
    end_sim();
  end
endmodule
`default_nettype wire
